/* File: core/acw_top.sv */
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// - Result at or above upper limit sets channel 7/6 high flag, bits 7/6.
// - Result strictly below lower limit sets channel 7/6 low flag, bits 5/4.
// - Limit flag low four bits read as ones; reset value 0Fh.
// - Software reset request via interrupt control write clears all four limit flags.
// - Any scan control write aborts conversion and re-initialises sequencing.
// - Start channel field picks first channel; increments up to channel 7.
// - Pin trigger enable lets next falling pin edge start a sequence.
// - Timer trigger enable lets timer event pulse start a sequence.
// - Enabled trigger sources are ORed; software should enable only one.
// - Any trigger sets run bit; single mode clears it at sequence end.
// - Bias enable zero idles the converter; one powers it.
// - Single mode: each start launches exactly one sequence.
// - Continuous mode: first sequence started, then repeats without triggers.
// - Writing run bit one starts, zero stops; scan control resets to zero.
// - End of conversion flag sets when a sequence completes.
// - Window alarm flag sets when channel 6 or 7 leaves its window.
// - Software writing either flag one raises a request too.
// - Bits 5 and 4 enable end and alarm requests; zero masks.
// - Bits 2:0 give priority level to the interrupt system; reset 0Fh.
// - Vector holds base in 7:2, source word in bit 1, zero bit 0.
// - Alarm request served before end of conversion, which stays pending.
// - Continuous mode restarts at start channel after channel 7.
// - Triggers arriving while run bit is set are ignored.
// - Channel result register reloads when that channel's conversion completes.
module acw_top (
  input wire logic CLK_SYS, // System clock
  input wire logic NRST, // Async reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [acw_pkg::ADDR_W-1:0] PADDR, // APB byte address
  input wire logic [acw_pkg::DATA_W-1:0] PWDATA, // APB write data
  output logic [acw_pkg::DATA_W-1:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic TRIGGER_INPUT_PIN, // External trigger pin
  input wire logic TIMER_EVENT, // Timer event pulse, same clock
  output acw_pkg::acw_conv_req_s CONV_REQ, // Conversion request
  input wire logic CONV_DONE, // Conversion finished pulse
  input wire logic [7:0] CONV_DATA, // Conversion result
  output logic ANALOG_BIAS_EN, // Analog section powered
  output logic IRQ_REQ, // Interrupt request
  output logic [2:0] IRQ_PRIORITY_LEVEL, // Interrupt priority
  output logic [7:0] IRQ_VECTOR // Vector with source word
);
  logic rst_n;
  logic pin_s;
  logic pin_prev_q;
  logic [7:0] res5_q, res6_q, res7_q;
  logic [7:0] lim_q [4];
  logic [3:0] flags_q;
  logic [3:0] hw_set;
  logic [2:0] first_q;
  logic pin_en_q, tmr_en_q, bias_q, repeat_q, run_q;
  logic end_flag_q, alarm_flag_q, end_en_q, alarm_en_q, icr_rsvd_q;
  logic [2:0] prio_q;
  logic [5:0] vbase_q;
  logic [31:0] prdata_q;
  logic [7:0] rd8;
  logic hit, access, wr;
  logic wr_sc, wr_ic, wr_lf;
  logic pin_fall, trig;
  logic chan_done, seq_end;
  logic end_req, alarm_req;
  logic [7:0] wd;

  acw_sync #(.RESET_VAL(1'b0)) u_rst_sync (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .d(1'b1),
    .q(rst_n)
  );

  // Pin idles high so that reset does not fake a falling edge
  acw_sync #(.RESET_VAL(1'b1)) u_pin_sync (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .d(TRIGGER_INPUT_PIN),
    .q(pin_s)
  );

  acw_scan u_scan (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .run(run_q),
    .bias(bias_q),
    .repeat_mode(repeat_q),
    .first_chan(first_q),
    .abort(wr_sc),
    .conv_done(CONV_DONE),
    .conv_req(CONV_REQ),
    .chan_done(chan_done),
    .seq_end(seq_end)
  );

  // Bus decode; zero wait states so every access phase completes
  assign wd = PWDATA[7:0];
  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE && hit;
  assign wr_sc = wr && (PADDR == acw_pkg::ADDR_SCAN_CONTROL);
  assign wr_ic = wr && (PADDR == acw_pkg::ADDR_IRQ_CONTROL);
  assign wr_lf = wr && (PADDR == acw_pkg::ADDR_LIMIT_FLAGS);
  assign PREADY = 1'b1;
  assign PSLVERR = access && !hit;
  assign PRDATA = prdata_q;

  always_comb begin
    hit = 1'b1;
    case (PADDR)
      acw_pkg::ADDR_CH5_RESULT: rd8 = res5_q;
      acw_pkg::ADDR_CH6_RESULT: rd8 = res6_q;
      acw_pkg::ADDR_CH7_RESULT: rd8 = res7_q;
      acw_pkg::ADDR_CH6_LOW_LIMIT: rd8 = lim_q[0];
      acw_pkg::ADDR_CH7_LOW_LIMIT: rd8 = lim_q[1];
      acw_pkg::ADDR_CH6_HIGH_LIMIT: rd8 = lim_q[2];
      acw_pkg::ADDR_CH7_HIGH_LIMIT: rd8 = lim_q[3];
      acw_pkg::ADDR_LIMIT_FLAGS: rd8 = {flags_q, acw_pkg::LF_RSVD};
      acw_pkg::ADDR_SCAN_CONTROL: rd8 = {first_q, pin_en_q, tmr_en_q, bias_q, repeat_q, run_q};
      acw_pkg::ADDR_IRQ_CONTROL: rd8 = {end_flag_q, alarm_flag_q, end_en_q, alarm_en_q, icr_rsvd_q, prio_q};
      acw_pkg::ADDR_IRQ_VECTOR: rd8 = IRQ_VECTOR;
      default: begin
        rd8 = 8'h00;
        hit = 1'b0;
      end
    endcase
  end

  // Read data is captured in the setup phase and held through access
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
    end else if (PSEL && !PENABLE) begin
      prdata_q <= {24'h0, rd8};
    end
  end

  // Triggers
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= pin_s;
    end
  end

  assign pin_fall = pin_prev_q && !pin_s;
  assign trig = (pin_fall && pin_en_q) || (TIMER_EVENT && tmr_en_q);

  // Scan control
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= acw_pkg::SC_RESET[acw_pkg::SC_FIRST_LSB +: 3];
      pin_en_q <= acw_pkg::SC_RESET[acw_pkg::SC_PIN_TRIG];
      tmr_en_q <= acw_pkg::SC_RESET[acw_pkg::SC_TIMER_TRIG];
      bias_q <= acw_pkg::SC_RESET[acw_pkg::SC_BIAS];
      repeat_q <= acw_pkg::SC_RESET[acw_pkg::SC_REPEAT];
    end else if (wr_sc) begin
      first_q <= wd[acw_pkg::SC_FIRST_LSB +: 3];
      pin_en_q <= wd[acw_pkg::SC_PIN_TRIG];
      tmr_en_q <= wd[acw_pkg::SC_TIMER_TRIG];
      bias_q <= wd[acw_pkg::SC_BIAS];
      repeat_q <= wd[acw_pkg::SC_REPEAT];
    end
  end

  // Run bit: a write decides, else trigger when idle, else single-mode end
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= acw_pkg::SC_RESET[acw_pkg::SC_RUN];
    end else if (wr_sc) begin
      run_q <= wd[acw_pkg::SC_RUN];
    end else if (trig && !run_q) begin
      run_q <= 1'b1;
    end else if (seq_end && !repeat_q) begin
      run_q <= 1'b0;
    end
  end

  assign ANALOG_BIAS_EN = bias_q;

  // Result registers; a completing conversion beats a software write
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      res5_q <= 8'h00;
      res6_q <= 8'h00;
      res7_q <= 8'h00;
    end else begin
      if (chan_done && CONV_REQ.chan == acw_pkg::CH5) begin
        res5_q <= CONV_DATA;
      end else if (wr && PADDR == acw_pkg::ADDR_CH5_RESULT) begin
        res5_q <= wd;
      end
      if (chan_done && CONV_REQ.chan == acw_pkg::CH6) begin
        res6_q <= CONV_DATA;
      end else if (wr && PADDR == acw_pkg::ADDR_CH6_RESULT) begin
        res6_q <= wd;
      end
      if (chan_done && CONV_REQ.chan == acw_pkg::CH7) begin
        res7_q <= CONV_DATA;
      end else if (wr && PADDR == acw_pkg::ADDR_CH7_RESULT) begin
        res7_q <= wd;
      end
    end
  end

  // Limits and flags: index 0 ch6 low, 1 ch7 low, 2 ch6 high, 3 ch7 high
  for (genvar i = 0; i < 4; i++) begin : g_win
    localparam logic [2:0] CH = (i % 2 == 1) ? acw_pkg::CH7 : acw_pkg::CH6;
    localparam logic [acw_pkg::ADDR_W-1:0] LADDR = (i == 0) ? acw_pkg::ADDR_CH6_LOW_LIMIT :
      (i == 1) ? acw_pkg::ADDR_CH7_LOW_LIMIT :
      (i == 2) ? acw_pkg::ADDR_CH6_HIGH_LIMIT : acw_pkg::ADDR_CH7_HIGH_LIMIT;
    if (i >= 2) begin : g_high
      assign hw_set[i] = chan_done && (CONV_REQ.chan == CH) && (CONV_DATA >= lim_q[i]);
    end else begin : g_low
      assign hw_set[i] = chan_done && (CONV_REQ.chan == CH) && (CONV_DATA < lim_q[i]);
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
        lim_q[i] <= 8'h00;
      end else if (wr && PADDR == LADDR) begin
        lim_q[i] <= wd;
      end
    end

    // Set wins over any clear in the same cycle; software can only clear
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
        flags_q[i] <= acw_pkg::LF_RESET[acw_pkg::LF_FLAG_LSB + i];
      end else if (hw_set[i]) begin
        flags_q[i] <= 1'b1;
      end else if (wr_ic && !wd[acw_pkg::IC_ALARM]) begin
        flags_q[i] <= 1'b0;
      end else if (wr_lf && !wd[acw_pkg::LF_FLAG_LSB + i]) begin
        flags_q[i] <= 1'b0;
      end
    end
  end

  // Interrupt control; software may set a flag to raise a request
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      end_flag_q <= acw_pkg::IC_RESET[acw_pkg::IC_END];
      alarm_flag_q <= acw_pkg::IC_RESET[acw_pkg::IC_ALARM];
      end_en_q <= acw_pkg::IC_RESET[acw_pkg::IC_END_EN];
      alarm_en_q <= acw_pkg::IC_RESET[acw_pkg::IC_ALARM_EN];
      icr_rsvd_q <= acw_pkg::IC_RESET[acw_pkg::IC_RSVD];
      prio_q <= acw_pkg::IC_RESET[2:0];
    end else begin
      end_flag_q <= (wr_ic ? wd[acw_pkg::IC_END] : end_flag_q) | seq_end;
      alarm_flag_q <= (wr_ic ? wd[acw_pkg::IC_ALARM] : alarm_flag_q) | (|hw_set);
      if (wr_ic) begin
        end_en_q <= wd[acw_pkg::IC_END_EN];
        alarm_en_q <= wd[acw_pkg::IC_ALARM_EN];
        icr_rsvd_q <= wd[acw_pkg::IC_RSVD];
        prio_q <= wd[acw_pkg::IC_PRIO_LSB +: 3];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      vbase_q <= acw_pkg::IV_BASE_RESET;
    end else if (wr && PADDR == acw_pkg::ADDR_IRQ_VECTOR) begin
      vbase_q <= wd[acw_pkg::IV_BASE_LSB +: 6];
    end
  end

  assign end_req = end_flag_q && end_en_q;
  assign alarm_req = alarm_flag_q && alarm_en_q;
  assign IRQ_REQ = end_req || alarm_req;
  assign IRQ_PRIORITY_LEVEL = prio_q;
  // Alarm owns the word select while pending; end request waits behind it
  assign IRQ_VECTOR = {vbase_q, !alarm_req, 1'b0};

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  sequence s_seq_finish;
    seq_end && !wr_sc && !wr_ic;
  endsequence

  sequence s_flag_read;
    PSEL && !PENABLE && PADDR == acw_pkg::ADDR_LIMIT_FLAGS;
  endsequence

  sequence s_sc_run;
    wr_sc && wd[acw_pkg::SC_RUN] && wd[acw_pkg::SC_BIAS] ##1 !wr_sc;
  endsequence

  flag_rsvd_a: assert property (s_flag_read |=> PRDATA[3:0] == 4'hf && PRDATA[31:8] == 24'h0)
    else $error("limit flag low bits not read as ones");
  high_flag_a: assert property (hw_set[3] |=> flags_q[3] && alarm_flag_q)
    else $error("ch7 high flag not set");
  low_flag_a: assert property (chan_done && CONV_REQ.chan == acw_pkg::CH6 && CONV_DATA < lim_q[0]
    |=> flags_q[0])
    else $error("ch6 low flag not set");
  icr_clear_a: assert property (wr_ic && !wd[acw_pkg::IC_ALARM] && hw_set == 4'h0 |=> flags_q == 4'h0)
    else $error("limit flags survive software reset");
  // The cycle after the write is always idle; a restart follows only one cycle later
  sc_abort_a: assert property (wr_sc |=> !CONV_REQ.start && !chan_done)
    else $error("conversion launched right after scan write");
  trig_run_a: assert property (trig && !run_q && !wr_sc |=> run_q)
    else $error("trigger did not set run bit");
  single_end_a: assert property (s_seq_finish ##0 !repeat_q |=> !run_q ##1 !CONV_REQ.start)
    else $error("single mode run bit not cleared");
  end_flag_a: assert property (s_seq_finish |=> end_flag_q)
    else $error("end flag not set at sequence end");
  alarm_first_a: assert property (alarm_req && end_req |-> IRQ_VECTOR[1:0] == 2'b00 && IRQ_REQ)
    else $error("alarm not served first");
  irq_mask_a: assert property (!end_en_q && !alarm_en_q |-> !IRQ_REQ)
    else $error("masked request reached output");
  sc_restart_a: assert property (s_sc_run |=> wr_sc || (CONV_REQ.start && CONV_REQ.chan == first_q))
    else $error("scan write did not restart at start channel");
  chan_step_a: assert property (chan_done && CONV_REQ.chan != acw_pkg::LAST_CHAN && run_q && bias_q
    |=> wr_sc || (CONV_REQ.start && CONV_REQ.chan == $past(CONV_REQ.chan) + 3'h1))
    else $error("channel did not advance");
  cont_wrap_a: assert property (seq_end && repeat_q && run_q && bias_q
    |=> wr_sc || (CONV_REQ.start && CONV_REQ.chan == first_q))
    else $error("continuous scan did not wrap to start channel");
  run_hold_a: assert property (run_q && !wr_sc && !seq_end |=> run_q)
    else $error("run bit dropped without write or sequence end");
  run_write_a: assert property (wr_sc |=> run_q == $past(wd[acw_pkg::SC_RUN]))
    else $error("run bit does not follow write");
  power_down_a: assert property (!ANALOG_BIAS_EN |-> !CONV_REQ.start && !chan_done)
    else $error("converter active while powered down");
  timer_trig_a: assert property (TIMER_EVENT && tmr_en_q && !run_q && !wr_sc |=> run_q)
    else $error("timer event did not set run bit");
  timer_off_a: assert property (TIMER_EVENT && !tmr_en_q && !(pin_fall && pin_en_q) && !run_q
    && !wr_sc |=> !run_q)
    else $error("disabled timer event set run bit");
  pin_trig_a: assert property (pin_fall && pin_en_q && !run_q && !wr_sc |=> run_q)
    else $error("pin edge did not set run bit");
  ch7_low_a: assert property (chan_done && CONV_REQ.chan == acw_pkg::CH7 && CONV_DATA < lim_q[1]
    |=> flags_q[1] && alarm_flag_q)
    else $error("ch7 low flag not set");
  ch6_high_a: assert property (chan_done && CONV_REQ.chan == acw_pkg::CH6 && CONV_DATA >= lim_q[2]
    |=> flags_q[2] && alarm_flag_q)
    else $error("ch6 high flag not set");
  soft_alarm_a: assert property (wr_ic && wd[acw_pkg::IC_ALARM] && wd[acw_pkg::IC_ALARM_EN]
    |=> IRQ_REQ && IRQ_VECTOR[1:0] == 2'b00)
    else $error("software alarm flag raised no request");
  prio_write_a: assert property (wr_ic |=> IRQ_PRIORITY_LEVEL == $past(wd[acw_pkg::IC_PRIO_LSB +: 3]))
    else $error("priority level does not follow write");
  lf_clear_a: assert property (wr_lf && hw_set == 4'h0
    |=> flags_q == ($past(flags_q) & $past(wd[acw_pkg::LF_FLAG_LSB +: 4])))
    else $error("limit flag write did not clear as written");
  res5_load_a: assert property (chan_done && CONV_REQ.chan == acw_pkg::CH5 |=> res5_q == $past(CONV_DATA))
    else $error("ch5 result not loaded");
endmodule

/* File: core/acw_pkg.sv */
package acw_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CH5_RESULT = 8'hf5;
  localparam logic [7:0] IDX_CH6_RESULT = 8'hf6;
  localparam logic [7:0] IDX_CH7_RESULT = 8'hf7;
  localparam logic [7:0] IDX_CH6_LOW_LIMIT = 8'hf8;
  localparam logic [7:0] IDX_CH7_LOW_LIMIT = 8'hf9;
  localparam logic [7:0] IDX_CH6_HIGH_LIMIT = 8'hfa;
  localparam logic [7:0] IDX_CH7_HIGH_LIMIT = 8'hfb;
  localparam logic [7:0] IDX_LIMIT_FLAGS = 8'hfc;
  localparam logic [7:0] IDX_SCAN_CONTROL = 8'hfd;
  localparam logic [7:0] IDX_IRQ_CONTROL = 8'hfe;
  localparam logic [7:0] IDX_IRQ_VECTOR = 8'hff;
  localparam logic [ADDR_W-1:0] ADDR_CH5_RESULT = {2'h0, IDX_CH5_RESULT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CH6_RESULT = {2'h0, IDX_CH6_RESULT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CH7_RESULT = {2'h0, IDX_CH7_RESULT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CH6_LOW_LIMIT = {2'h0, IDX_CH6_LOW_LIMIT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CH7_LOW_LIMIT = {2'h0, IDX_CH7_LOW_LIMIT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CH6_HIGH_LIMIT = {2'h0, IDX_CH6_HIGH_LIMIT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CH7_HIGH_LIMIT = {2'h0, IDX_CH7_HIGH_LIMIT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_LIMIT_FLAGS = {2'h0, IDX_LIMIT_FLAGS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SCAN_CONTROL = {2'h0, IDX_SCAN_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CONTROL = {2'h0, IDX_IRQ_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_VECTOR = {2'h0, IDX_IRQ_VECTOR, 2'h0};
  // scan_control fields
  localparam int unsigned SC_FIRST_LSB = 5;
  localparam int unsigned SC_PIN_TRIG = 4;
  localparam int unsigned SC_TIMER_TRIG = 3;
  localparam int unsigned SC_BIAS = 2;
  localparam int unsigned SC_REPEAT = 1;
  localparam int unsigned SC_RUN = 0;
  localparam logic [7:0] SC_RESET = 8'h00;
  // converter_irq_control fields
  localparam int unsigned IC_END = 7;
  localparam int unsigned IC_ALARM = 6;
  localparam int unsigned IC_END_EN = 5;
  localparam int unsigned IC_ALARM_EN = 4;
  localparam int unsigned IC_RSVD = 3;
  localparam int unsigned IC_PRIO_LSB = 0;
  localparam logic [7:0] IC_RESET = 8'h0f;
  // limit_flags: bits 7..4 flags, bits 3..0 read as ones
  localparam int unsigned LF_FLAG_LSB = 4;
  localparam logic [3:0] LF_RSVD = 4'hf;
  localparam logic [7:0] LF_RESET = 8'h0f;
  // converter_irq_vector
  localparam int unsigned IV_BASE_LSB = 2;
  localparam logic [5:0] IV_BASE_RESET = 6'h00;
  localparam logic [2:0] LAST_CHAN = 3'h7;
  localparam logic [2:0] CH5 = 3'h5;
  localparam logic [2:0] CH6 = 3'h6;
  localparam logic [2:0] CH7 = 3'h7;

  typedef enum logic [1:0] {SCAN_IDLE, SCAN_LAUNCH, SCAN_WAIT} acw_scan_e;

  typedef struct packed {
    logic start;
    logic abort;
    logic [2:0] chan;
  } acw_conv_req_s;
endpackage

/* File: core/acw_sync.sv */
`timescale 1ns/1ps
module acw_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk, // Sampling clock
  input wire logic rst_n, // Async reset, active low
  input wire logic d, // Asynchronous level
  output logic q // Synchronised level
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: core/acw_scan.sv */
`timescale 1ns/1ps
module acw_scan (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic run, // Run bit
  input wire logic bias, // Converter powered
  input wire logic repeat_mode, // Continuous mode
  input wire logic [2:0] first_chan, // Start channel
  input wire logic abort, // Scan control written
  input wire logic conv_done, // Conversion finished
  output acw_pkg::acw_conv_req_s conv_req, // Request to analog side
  output logic chan_done, // Current channel finished
  output logic seq_end // Last channel finished
);
  acw_pkg::acw_scan_e state_q;
  logic [2:0] chan_q;

  assign chan_done = (state_q == acw_pkg::SCAN_WAIT) && conv_done && !abort;
  assign seq_end = chan_done && (chan_q == acw_pkg::LAST_CHAN);
  assign conv_req.start = (state_q == acw_pkg::SCAN_LAUNCH) && run && bias && !abort;
  assign conv_req.abort = abort && (state_q != acw_pkg::SCAN_IDLE);
  assign conv_req.chan = chan_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= acw_pkg::SCAN_IDLE;
      chan_q <= 3'h0;
    end else if (abort || !run || !bias) begin
      // Power-down or stop drops any sequence in flight
      state_q <= acw_pkg::SCAN_IDLE;
    end else begin
      case (state_q)
        acw_pkg::SCAN_IDLE: begin
          chan_q <= first_chan;
          state_q <= acw_pkg::SCAN_LAUNCH;
        end
        acw_pkg::SCAN_LAUNCH: begin
          state_q <= acw_pkg::SCAN_WAIT;
        end
        acw_pkg::SCAN_WAIT: begin
          if (conv_done) begin
            if (chan_q == acw_pkg::LAST_CHAN) begin
              chan_q <= first_chan;
              state_q <= repeat_mode ? acw_pkg::SCAN_LAUNCH : acw_pkg::SCAN_IDLE;
            end else begin
              chan_q <= chan_q + 3'h1;
              state_q <= acw_pkg::SCAN_LAUNCH;
            end
          end
        end
        default: begin
          state_q <= acw_pkg::SCAN_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: testbench/acw_analog_model.sv */
`timescale 1ns/1ps
module acw_analog_model (
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input acw_pkg::acw_conv_req_s req, // Request from the block
  input wire logic [3:0] lat, // Extra cycles per conversion
  input wire logic [63:0] vals, // Result per channel, channel 0 lowest
  output logic done, // Conversion finished pulse
  output logic [7:0] data // Result, valid with done only
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic [2:0] chan_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      chan_q <= 3'h0;
      done <= 1'b0;
      data <= 8'h00;
    end else begin
      done <= 1'b0;
      // Data toggles outside the done cycle so a stale sample never matches
      data <= ~data;
      if (req.abort) begin
        busy_q <= 1'b0;
      end else if (req.start) begin
        busy_q <= 1'b1;
        chan_q <= req.chan;
        cnt_q <= lat;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        done <= 1'b1;
        data <= vals[chan_q*8 +: 8];
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

/* File: testbench/adc_autoscan_window_control_bench.sv */
`timescale 1ns/1ps
module adc_autoscan_window_control_bench;
  logic CLK_SYS, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TRIGGER_INPUT_PIN, TIMER_EVENT;
  logic CONV_DONE, ANALOG_BIAS_EN, IRQ_REQ;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [7:0] CONV_DATA, IRQ_VECTOR;
  logic [2:0] IRQ_PRIORITY_LEVEL;
  logic [3:0] lat;
  logic [63:0] vals;
  acw_pkg::acw_conv_req_s CONV_REQ;
  int err_total, num_checks, n_abort;
  logic [2:0] chq[$];

  acw_top dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TRIGGER_INPUT_PIN(TRIGGER_INPUT_PIN), .TIMER_EVENT(TIMER_EVENT), .CONV_REQ(CONV_REQ),
    .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .ANALOG_BIAS_EN(ANALOG_BIAS_EN), .IRQ_REQ(IRQ_REQ),
    .IRQ_PRIORITY_LEVEL(IRQ_PRIORITY_LEVEL), .IRQ_VECTOR(IRQ_VECTOR));
  acw_analog_model far (.clk(CLK_SYS), .rst_n(NRST), .req(CONV_REQ), .lat(lat), .vals(vals),
    .done(CONV_DONE), .data(CONV_DATA));

  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) if (CONV_REQ.start === 1'b1) chq.push_back(CONV_REQ.chan);
  always @(posedge CLK_SYS) if (CONV_REQ.abort === 1'b1) n_abort++;

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic er);
    int n;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n == 20) begin
      err_total++;
      results();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Let registered outputs settle before callers look at them
    @(negedge CLK_SYS);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, {24'h0, d}, rd, er);
  endtask
  task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, exp_err});
  endtask
  task automatic wait_idle;
    logic [31:0] rd;
    logic er;
    int n;
    n = 0;
    do begin
      apb(1'b0, acw_pkg::ADDR_SCAN_CONTROL, 32'h0, rd, er);
      n++;
    end while (rd[0] !== 1'b0 && n < 60);
    if (n == 60) begin
      err_total++;
      results();
    end
  endtask
  task automatic pulse_timer;
    @(posedge CLK_SYS) TIMER_EVENT <= 1'b1;
    @(posedge CLK_SYS) TIMER_EVENT <= 1'b0;
  endtask

  task automatic t_reset;
    chk_reg(acw_pkg::ADDR_LIMIT_FLAGS, 32'h0f, 1'b0);
    chk_reg(acw_pkg::ADDR_SCAN_CONTROL, 32'h00, 1'b0);
    chk_reg(acw_pkg::ADDR_IRQ_CONTROL, 32'h0f, 1'b0);
    chk({29'h0, IRQ_PRIORITY_LEVEL}, 32'h7);
    chk({24'h0, IRQ_VECTOR}, 32'h02);
    chk_reg(12'h010, 32'h0, 1'b1);
    wr(acw_pkg::ADDR_LIMIT_FLAGS, 8'h00);
    chk_reg(acw_pkg::ADDR_LIMIT_FLAGS, 32'h0f, 1'b0);
  endtask

  task automatic t_window;
    lat = 4'h2;
    vals = 64'h2080_1100_0000_0000;
    wr(acw_pkg::ADDR_CH6_HIGH_LIMIT, 8'h80);
    wr(acw_pkg::ADDR_CH7_LOW_LIMIT, 8'h21);
    wr(acw_pkg::ADDR_CH7_HIGH_LIMIT, 8'hff);
    wr(acw_pkg::ADDR_IRQ_VECTOR, 8'ha8);
    chq.delete();
    wr(acw_pkg::ADDR_SCAN_CONTROL, 8'ha5);
    chk({31'h0, ANALOG_BIAS_EN}, 32'h1);
    wait_idle();
    chk(chq.size(), 3);
    for (int i = 0; i < 3; i++) chk({29'h0, chq[i]}, 5 + i);
    chk_reg(acw_pkg::ADDR_CH5_RESULT, 32'h11, 1'b0);
    chk_reg(acw_pkg::ADDR_CH6_RESULT, 32'h80, 1'b0);
    chk_reg(acw_pkg::ADDR_CH7_RESULT, 32'h20, 1'b0);
    chk_reg(acw_pkg::ADDR_LIMIT_FLAGS, 32'h6f, 1'b0);
    chk_reg(acw_pkg::ADDR_IRQ_CONTROL, 32'hcf, 1'b0);
    chk({31'h0, IRQ_REQ}, 32'h0);
    wr(acw_pkg::ADDR_IRQ_CONTROL, 8'hbf);
    chk_reg(acw_pkg::ADDR_LIMIT_FLAGS, 32'h0f, 1'b0);
    chk({31'h0, IRQ_REQ}, 32'h1);
    chk({24'h0, IRQ_VECTOR}, 32'haa);
    wr(acw_pkg::ADDR_IRQ_CONTROL, 8'hff);
    chk({24'h0, IRQ_VECTOR}, 32'ha8);
    wr(acw_pkg::ADDR_IRQ_CONTROL, 8'h3a);
    chk({31'h0, IRQ_REQ}, 32'h0);
    chk({29'h0, IRQ_PRIORITY_LEVEL}, 32'h2);
  endtask

  task automatic t_cont;
    int n;
    lat = 4'h0;
    chq.delete();
    wr(acw_pkg::ADDR_SCAN_CONTROL, 8'hc7);
    repeat (30) @(posedge CLK_SYS);
    wr(acw_pkg::ADDR_SCAN_CONTROL, 8'h04);
    n = chq.size();
    chk({31'h0, n >= 4}, 32'h1);
    for (int i = 0; i < n; i++) chk({29'h0, chq[i]}, (i % 2) ? 7 : 6);
    repeat (20) @(posedge CLK_SYS);
    chk(chq.size(), n);
    chk(n_abort, 1);
  endtask

  task automatic t_trig;
    lat = 4'h8;
    chq.delete();
    wr(acw_pkg::ADDR_SCAN_CONTROL, 8'he4);
    pulse_timer();
    @(posedge CLK_SYS) TRIGGER_INPUT_PIN <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    TRIGGER_INPUT_PIN <= 1'b1;
    repeat (20) @(posedge CLK_SYS);
    chk(chq.size(), 0);
    wr(acw_pkg::ADDR_SCAN_CONTROL, 8'hec);
    pulse_timer();
    repeat (3) @(posedge CLK_SYS);
    pulse_timer();
    wait_idle();
    chk(chq.size(), 1);
    chq.delete();
    wr(acw_pkg::ADDR_SCAN_CONTROL, 8'hf4);
    @(posedge CLK_SYS) TRIGGER_INPUT_PIN <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    TRIGGER_INPUT_PIN <= 1'b1;
    repeat (5) @(posedge CLK_SYS);
    wait_idle();
    chk(chq.size(), 1);
    chq.delete();
    wr(acw_pkg::ADDR_SCAN_CONTROL, 8'he1);
    repeat (20) @(posedge CLK_SYS);
    chk(chq.size(), 0);
    chk({31'h0, ANALOG_BIAS_EN}, 32'h0);
  endtask

  initial begin
    err_total = 0;
    num_checks = 0;
    n_abort = 0;
    NRST = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    TRIGGER_INPUT_PIN = 1'b1;
    TIMER_EVENT = 1'b0;
    lat = 4'h0;
    vals = 64'h0;
    repeat (16) @(posedge CLK_SYS);
    NRST <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    t_reset();
    t_window();
    t_cont();
    t_trig();
    results();
  end
endmodule
